// ===== inc/dics_pkg.sv
package dics_pkg;

    // ==========================================================
    // group geometry
    // ==========================================================
    localparam int GROUP_W      = 16;           // bits per input group
    localparam int TOTAL_BITS   = 1024;         // sense + counter capacity
    localparam int NUM_ADDR     = TOTAL_BITS / GROUP_W;
    localparam int NUM_DI       = 32;           // sense groups fitted
    localparam int NUM_CTR      = NUM_ADDR - NUM_DI;
    localparam int PI_BITS      = 384;          // interrupt capacity
    localparam int NUM_PI       = PI_BITS / GROUP_W;
    localparam int PI_LEVELS    = 4;            // levels per interrupt group
    localparam int PI_PER_LVL   = GROUP_W / PI_LEVELS;
    localparam int CTR_W        = 8;            // one narrow counter

    // ==========================================================
    // modifier decode
    // ==========================================================
    localparam logic [6:0] MOD_DI_BASE  = 7'h0040;  // first sense group
    localparam logic [6:0] MOD_CTR_TOP  = 7'h007F;  // counter pair 0
    localparam logic [6:0] MOD_PI_LAST  = 7'h0017;  // last interrupt group
    localparam int         MOD_SYNC_BIT = 7;        // modifier bit 8, msb-0

    // ==========================================================
    // command encodings
    // ==========================================================
    typedef enum logic [1:0] {
        DICS_FN_READ  = 2'h0,   // one group to storage
        DICS_FN_SENSE = 2'h1,   // one group to accumulator
        DICS_FN_INIT  = 2'h2,   // channel initialize read
        DICS_FN_NONE  = 2'h3
    } dics_fn_e;

    typedef enum logic [1:0] {
        DICS_AM_SEQ    = 2'h0,
        DICS_AM_RANDOM = 2'h1,
        DICS_AM_SINGLE = 2'h2,
        DICS_AM_RSVD   = 2'h3
    } dics_amode_e;

    typedef struct packed {
        dics_fn_e    func;
        dics_amode_e amode;
        logic [15:0] modifier;
        logic [15:0] mem_addr;
        logic [15:0] word_count;
    } dics_cmd_s;

    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
        logic [15:0] data;
    } dics_mem_wr_s;

endpackage

// ===== verilog/dics_pulse_counter.sv
`timescale 1ns/100ps
module dics_pulse_counter
    import dics_pkg::*;
(
    input  wire logic                 i_ref_clk,  // system clock
    input  wire logic                 i_rstn,     // async reset, low
    input  wire logic [1:0]           i_pulse,    // pulse inputs, level
    input  wire logic                 i_wide,     // one 16-bit counter
    input  wire logic                 i_clear,    // read strobe
    output logic      [GROUP_W-1:0]   o_value     // packed counter word
);

    // ==========================================================
    // edge detect and count
    // ==========================================================
    logic [1:0]         pulse_d_reg;
    logic [GROUP_W-1:0] cnt_reg;
    logic [GROUP_W-1:0] cnt_next;
    logic [1:0]         rise;
    logic [GROUP_W-1:0] base;

    assign rise = i_pulse & ~pulse_d_reg;
    assign base = i_clear ? '0 : cnt_reg;                            // [R17]

    always_comb begin
        cnt_next = base;
        if (i_wide) begin
            cnt_next = base + GROUP_W'(rise[0]);                     // [R17]
        end else begin
            cnt_next[CTR_W-1:0]       = base[CTR_W-1:0] + CTR_W'(rise[0]);
            cnt_next[GROUP_W-1:CTR_W] = base[GROUP_W-1:CTR_W] + CTR_W'(rise[1]);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pulse_d_reg <= '0;
            cnt_reg     <= '0;
        end else begin
            pulse_d_reg <= i_pulse;
            cnt_reg     <= cnt_next;
        end
    end

    assign o_value = cnt_reg;                                        // [R06]

endmodule // dics_pulse_counter

// ===== verilog/dics_input_channel.sv
`timescale 1ns/100ps
// Contract
// [R01] groups are 16 bits, contents unformatted
// [R02] programmed read stores exactly one group
// [R03] channel start moves many groups, one per cycle; code spends at least two cycles per group
// [R04] sequential, random or single-address channel reads
// [R05] interrupt groups feed four levels, four each
// [R06] counter read gives two 8-bit or one 16-bit
// [R07] sense plus counter capacity 1024 bits
// [R08] interrupt capacity 24 groups, 384 bits
// [R09] modifier bit 8 selects synchronized read
// [R10] synchronized initialize raises sync ready
// [R11] field device sets data before sync pulse
// [R12] sync pulse stores group, drops ready
// [R13] synchronized: interlocked until count zero, cpu free
// [R14] unsynchronized: transfer done before next instruction
// [R15] closed or positive reads one
// [R16] input n lands at bit n
// [R17] counters count pulses, clear on read
// [R18] sync pulses while not ready ignored
module dics_input_channel
    import dics_pkg::*;
(
    input  wire logic                      i_ref_clk,    // 100 MHz clock
    input  wire logic                      i_rstn,       // async reset, low
    input  wire logic                      i_cmd_valid,  // command offered
    input  wire dics_cmd_s                 i_cmd,        // command word
    output logic                           o_cmd_ready,  // command taken
    input  wire logic [6:0]                i_rand_group, // random-mode group
    output dics_mem_wr_s                   o_mem_wr,     // storage write
    input  wire logic                      i_mem_ack,    // storage cycle done
    output logic                           o_acc_valid,  // accumulator strobe
    output logic      [GROUP_W-1:0]        o_acc_data,   // accumulator data
    output logic                           o_interlock,  // input function busy
    output logic                           o_cpu_hold,   // stall processor
    output logic                           o_sync_ready, // toward field device
    input  wire logic                      i_ext_sync,   // sync pulse in
    input  wire logic [NUM_DI*GROUP_W-1:0] i_sense,      // sense inputs
    input  wire logic [NUM_CTR*2-1:0]      i_ctr_pulse,  // counter pulses
    input  wire logic [NUM_CTR-1:0]        i_ctr_wide,   // 16-bit counter mode
    input  wire logic [PI_BITS-1:0]        i_pi_in,      // interrupt inputs
    output logic      [NUM_PI*PI_LEVELS-1:0] o_pi_level  // level requests
);

    // ==========================================================
    // state machine
    // ==========================================================
    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0001,
        ST_WSYNC   = 4'b0010,
        ST_CAPTURE = 4'b0100,
        ST_STORE   = 4'b1000
    } dics_state_e;

    dics_state_e  state_reg;
    dics_state_e  state_next;
    dics_fn_e     func_reg;
    dics_amode_e  amode_reg;
    logic         sync_reg;
    logic [6:0]   group_reg;
    logic [15:0]  addr_reg;
    logic [15:0]  wc_reg;
    logic [15:0]  data_reg;
    logic         ready_reg;
    logic         acc_v_reg;
    logic [15:0]  acc_reg;

    // ==========================================================
    // group selection
    // ==========================================================
    logic [GROUP_W-1:0] ctr_val [NUM_CTR];
    logic [NUM_CTR-1:0] ctr_clr;
    logic [PI_BITS-1:0] pi_reg;
    logic [PI_BITS-1:0] pi_d_reg;
    logic [PI_BITS-1:0] pi_clr;
    logic [6:0]         cur_group;
    logic               is_di;
    logic               is_ctr;
    logic               is_pi;
    logic [4:0]         di_idx;
    logic [4:0]         ctr_idx;
    logic [4:0]         pi_idx;
    logic [15:0]        sel_word;
    logic               capture;
    logic               sync_hit;
    logic               last_word;
    logic               cmd_take;
    logic               cmd_sync;

    assign cur_group = (amode_reg == DICS_AM_RANDOM && func_reg == DICS_FN_INIT)
                       ? i_rand_group : group_reg;                   // [R04]
    assign is_di   = (cur_group >= MOD_DI_BASE) &&
                     (cur_group < MOD_DI_BASE + 7'(NUM_DI));         // [R07]
    assign is_ctr  = (cur_group >= MOD_DI_BASE + 7'(NUM_DI));        // [R07]
    assign is_pi   = (cur_group <= MOD_PI_LAST);                     // [R08]
    assign di_idx  = 5'(cur_group - MOD_DI_BASE);
    assign ctr_idx = 5'(MOD_CTR_TOP - cur_group);
    assign pi_idx  = cur_group[4:0];

    // sense word passes through untouched, bit n from input n
    assign sel_word = is_di  ? i_sense[di_idx*GROUP_W +: GROUP_W] :  // [R01] [R15] [R16]
                      is_ctr ? ctr_val[ctr_idx] :                    // [R06]
                      is_pi  ? pi_reg[pi_idx*GROUP_W +: GROUP_W] :
                      '0;

    assign capture   = (state_reg == ST_CAPTURE);
    assign sync_hit  = (state_reg == ST_WSYNC) && ready_reg && i_ext_sync; // [R12] [R18]
    assign last_word = (wc_reg <= 16'h0001);
    assign cmd_take  = i_cmd_valid && o_cmd_ready;
    assign cmd_sync  = (i_cmd.func == DICS_FN_INIT) && i_cmd.modifier[MOD_SYNC_BIT]; // [R09]

    // ==========================================================
    // counters and interrupt latches
    // ==========================================================
    genvar g;
    generate
        for (g = 0; g < NUM_CTR; g++) begin : g_ctr
            assign ctr_clr[g] = capture && is_ctr && (ctr_idx == 5'(g)); // [R17]
            dics_pulse_counter u_ctr (
                .i_ref_clk (i_ref_clk),
                .i_rstn    (i_rstn),
                .i_pulse   (i_ctr_pulse[2*g +: 2]),
                .i_wide    (i_ctr_wide[g]),
                .i_clear   (ctr_clr[g]),
                .o_value   (ctr_val[g])
            );
        end
        for (g = 0; g < NUM_PI; g++) begin : g_pi
            assign pi_clr[g*GROUP_W +: GROUP_W] =
                {GROUP_W{capture && is_pi && (pi_idx == 5'(g))}};
            for (genvar l = 0; l < PI_LEVELS; l++) begin : g_lvl
                assign o_pi_level[g*PI_LEVELS + l] =
                    |pi_reg[g*GROUP_W + l*PI_PER_LVL +: PI_PER_LVL]; // [R05]
            end
        end
    endgenerate

    // set wins over the read clear
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pi_reg   <= '0;
            pi_d_reg <= '0;
        end else begin
            pi_d_reg <= i_pi_in;
            pi_reg   <= (pi_reg & ~pi_clr) | (i_pi_in & ~pi_d_reg);   // [R05]
        end
    end

    // ==========================================================
    // transfer sequencing
    // ==========================================================
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (cmd_take && i_cmd.func != DICS_FN_NONE) begin
                    state_next = cmd_sync ? ST_WSYNC : ST_CAPTURE;   // [R09] [R10]
                end
            end
            ST_WSYNC: begin
                if (sync_hit) begin
                    state_next = ST_CAPTURE;                         // [R11] [R12]
                end
            end
            ST_CAPTURE: begin
                state_next = (func_reg == DICS_FN_SENSE) ? ST_IDLE : ST_STORE;
            end
            ST_STORE: begin
                if (i_mem_ack) begin
                    if (func_reg != DICS_FN_INIT || last_word) begin
                        state_next = ST_IDLE;                        // [R02] [R13]
                    end else begin
                        state_next = sync_reg ? ST_WSYNC : ST_CAPTURE; // [R03]
                    end
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg <= ST_IDLE;
            func_reg  <= DICS_FN_NONE;
            amode_reg <= DICS_AM_SEQ;
            sync_reg  <= 1'b0;
            group_reg <= '0;
            addr_reg  <= '0;
            wc_reg    <= '0;
        end else begin
            state_reg <= state_next;
            if (cmd_take) begin
                func_reg  <= i_cmd.func;
                amode_reg <= i_cmd.amode;
                sync_reg  <= cmd_sync;
                group_reg <= i_cmd.modifier[6:0];
                addr_reg  <= i_cmd.mem_addr;
                wc_reg    <= i_cmd.word_count;
            end else if (state_reg == ST_STORE && i_mem_ack) begin
                addr_reg <= addr_reg + 16'h0001;                     // [R03]
                wc_reg   <= wc_reg - 16'h0001;
                if (amode_reg == DICS_AM_SEQ) begin
                    group_reg <= group_reg + 7'h01;                  // [R04]
                end
            end
        end
    end

    // ==========================================================
    // data capture and sync ready
    // ==========================================================
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            data_reg  <= '0;
            acc_reg   <= '0;
            acc_v_reg <= 1'b0;
        end else begin
            acc_v_reg <= capture && (func_reg == DICS_FN_SENSE);
            if (capture) begin
                data_reg <= sel_word;                                // [R01]
                if (func_reg == DICS_FN_SENSE) begin
                    acc_reg <= sel_word;
                end
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ready_reg <= 1'b0;
        end else if (cmd_take && cmd_sync) begin
            ready_reg <= 1'b1;                                       // [R10]
        end else if (sync_hit) begin
            ready_reg <= 1'b0;                                       // [R12]
        end else if (state_reg == ST_STORE && i_mem_ack && sync_reg && !last_word) begin
            ready_reg <= 1'b1;
        end
    end

    // ==========================================================
    // outputs
    // ==========================================================
    assign o_cmd_ready    = (state_reg == ST_IDLE);
    assign o_mem_wr.valid = (state_reg == ST_STORE);                 // [R03]
    assign o_mem_wr.addr  = addr_reg;
    assign o_mem_wr.data  = data_reg;
    assign o_acc_valid    = acc_v_reg;
    assign o_acc_data     = acc_reg;
    assign o_sync_ready   = ready_reg;
    assign o_interlock    = (state_reg != ST_IDLE);                  // [R13]
    assign o_cpu_hold     = (state_reg != ST_IDLE) && !sync_reg;     // [R14]

endmodule // dics_input_channel

// ===== testbench/dics_monitor.sv
`timescale 1ns/100ps
module dics_monitor
    import dics_pkg::*;
(
    input  wire logic         i_ref_clk,    // clock
    input  wire logic         i_rstn,       // reset, low
    input  wire logic         i_cmd_valid,  // command offered
    input  wire dics_cmd_s    i_cmd,        // command word
    input  wire logic         o_cmd_ready,  // idle
    input  wire dics_mem_wr_s o_mem_wr,     // storage write
    input  wire logic         i_mem_ack,    // storage done
    input  wire logic         o_acc_valid,  // accumulator strobe
    input  wire logic         o_interlock,  // busy
    input  wire logic         o_cpu_hold,   // stall
    input  wire logic         o_sync_ready, // field ready
    input  wire logic         i_ext_sync    // sync pulse
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    wire take    = i_cmd_valid && o_cmd_ready;
    wire sync_on = i_cmd.modifier[MOD_SYNC_BIT];
    wire is_init = i_cmd.func == DICS_FN_INIT;

    // ==========================================================
    // assertions
    // ==========================================================
    a_ready_idle: assert property (o_cmd_ready == !o_interlock)
        else $error("ready and interlock disagree");
    a_read_store: assert property (take && i_cmd.func == DICS_FN_READ
        |-> ##2 o_mem_wr.valid)
        else $error("read write late");
    a_sense_strobe: assert property (take && i_cmd.func == DICS_FN_SENSE
        |-> ##2 o_acc_valid ##1 !o_acc_valid)
        else $error("sense strobe wrong");
    a_sync_arm: assert property (take && is_init && sync_on
        |=> o_sync_ready && !o_cpu_hold)
        else $error("sync ready not raised");
    a_unsync_hold: assert property (take && is_init && !sync_on
        |=> o_cpu_hold ##1 o_mem_wr.valid)
        else $error("unsync start wrong");
    a_sync_store: assert property (o_sync_ready && i_ext_sync
        |=> !o_sync_ready ##1 o_mem_wr.valid)
        else $error("sync pulse not served");
    a_sync_free: assert property (o_sync_ready |-> !o_cpu_hold && o_interlock)
        else $error("cpu held in sync mode");
    a_stray_sync: assert property (!o_sync_ready && i_ext_sync && o_cmd_ready
        && !i_cmd_valid |=> o_cmd_ready [*2])
        else $error("stray sync acted on");
    a_write_hold: assert property (o_mem_wr.valid && !i_mem_ack
        |=> o_mem_wr.valid && $stable(o_mem_wr.addr) && $stable(o_mem_wr.data))
        else $error("write dropped early");
    a_idle_quiet: assert property (o_cmd_ready |-> !o_mem_wr.valid && !o_sync_ready)
        else $error("idle with activity");
    c_sync_init: cover property (take && is_init && sync_on);
    c_sync_pulse: cover property (o_sync_ready && i_ext_sync);
    c_write_ack: cover property (o_mem_wr.valid && i_mem_ack);
    c_acc: cover property (o_acc_valid);
endmodule // dics_monitor

bind dics_input_channel dics_monitor u_mon (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
    .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .o_cmd_ready(o_cmd_ready), .o_mem_wr(o_mem_wr),
    .i_mem_ack(i_mem_ack), .o_acc_valid(o_acc_valid), .o_interlock(o_interlock),
    .o_cpu_hold(o_cpu_hold), .o_sync_ready(o_sync_ready), .i_ext_sync(i_ext_sync));

// ===== testbench/dics_field_model.sv
`timescale 1ns/100ps
module dics_field_model
    import dics_pkg::*;
(
    input  wire logic               i_ref_clk,    // clock
    input  wire logic               i_rstn,       // reset, low
    input  wire logic               i_sync_ready, // adapter waiting
    input  wire logic [3:0]         i_delay,      // reaction cycles, 1 up
    input  wire logic [GROUP_W-1:0] i_seed,       // first word less one
    output logic      [GROUP_W-1:0] o_data,       // addressed group
    output logic                    o_sync        // sync pulse
);
    logic [4:0]         cnt_reg;
    logic [GROUP_W-1:0] seq_reg;
    wire  [4:0]         d = {1'b0, i_delay};
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_reg <= '0;
            seq_reg <= '0;
            o_data  <= '0;
            o_sync  <= 1'b0;
        end else if (cnt_reg == 5'h0) begin
            if (i_sync_ready) cnt_reg <= 5'h1;
        end else begin
            cnt_reg <= cnt_reg + 5'h1;
            if (cnt_reg == d) begin
                seq_reg <= seq_reg + 16'h1;
                o_data  <= i_seed + seq_reg + 16'h1;
            end
            if (cnt_reg == d + 5'h1) o_sync <= 1'b1;
            if (cnt_reg == d + 5'h2) o_sync <= 1'b0;
            // data no longer held: show its inverse
            if (cnt_reg == d + 5'h4) begin
                o_data  <= ~o_data;
                cnt_reg <= '0;
            end
        end
    end
endmodule // dics_field_model

// ===== testbench/tb.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb;
    import dics_pkg::*;
    logic clk, rstn, cv, ack, tsync, fsync, rdy, sr, accv, il, hold;
    logic [6:0]                  rg;
    logic [3:0]                  dly;
    logic [GROUP_W-1:0]          accd, fdata;
    logic [NUM_DI*GROUP_W-1:0]   sense;
    logic [NUM_CTR*2-1:0]        cpul;
    logic [NUM_CTR-1:0]          wide;
    logic [PI_BITS-1:0]          pi;
    logic [NUM_PI*PI_LEVELS-1:0] lvl;
    dics_cmd_s                   cmd;
    dics_mem_wr_s                wr;
    int                          n_fail, num_checks;
    wire ext_sync = tsync | fsync;
    wire [NUM_DI*GROUP_W-1:0] sense_w = {sense[NUM_DI*GROUP_W-1:GROUP_W], fdata};

    dics_input_channel DUT (.i_ref_clk(clk), .i_rstn(rstn), .i_cmd_valid(cv), .i_cmd(cmd),
        .o_cmd_ready(rdy), .i_rand_group(rg), .o_mem_wr(wr), .i_mem_ack(ack), .o_acc_valid(accv),
        .o_acc_data(accd), .o_interlock(il), .o_cpu_hold(hold), .o_sync_ready(sr),
        .i_ext_sync(ext_sync), .i_sense(sense_w), .i_ctr_pulse(cpul), .i_ctr_wide(wide),
        .i_pi_in(pi), .o_pi_level(lvl));
    dics_field_model u_fd (.i_ref_clk(clk), .i_rstn(rstn), .i_sync_ready(sr), .i_delay(dly),
        .i_seed(16'hA5A0), .o_data(fdata), .o_sync(fsync));

    function automatic logic [15:0] grp(int g);
        return (g == 1) ? 16'h8001 : 16'h0A00 + 16'(g);
    endfunction
    task automatic issue(dics_fn_e f, dics_amode_e m, logic [15:0] md, a, n);
        @(posedge clk);
        cv  <= 1'b1;
        cmd <= '{f, m, md, a, n};
        @(posedge clk);
        cv  <= 1'b0;
    endtask
    task automatic take_word(string nm, logic [15:0] a, d);
        int k = 0;
        do begin @(negedge clk); k++; end while (wr.valid !== 1'b1 && k < 50);
        `CHK(nm, 1'b1, wr.valid)
        `CHK(nm, a, wr.addr)
        `CHK(nm, d, wr.data)
        @(posedge clk) ack <= 1'b1;
        @(posedge clk) ack <= 1'b0;
    endtask
    task automatic pulses(int b, int n);
        repeat (n) begin
            @(posedge clk) cpul[b] <= 1'b1;
            @(posedge clk) cpul[b] <= 1'b0;
        end
    endtask
    task automatic settle();
        repeat (2) @(negedge clk);
        `CHK("idle", 1'b1, rdy)
        `CHK("nowrite", 1'b0, wr.valid)
    endtask
    task automatic t_direct();
        int k = 0;
        for (int g = 1; g < 4; g++) begin
            issue(DICS_FN_READ, DICS_AM_SEQ, 16'h0040 + 16'(g), 16'h0100 + 16'(g), 16'h1);
            take_word("read", 16'h0100 + 16'(g), grp(g));
            settle();
        end
        issue(DICS_FN_NONE, DICS_AM_SEQ, 16'h0041, 16'h0500, 16'h1);
        settle();
        issue(DICS_FN_READ, DICS_AM_SEQ, 16'h0030, 16'h0200, 16'h1);
        take_word("unmapped", 16'h0200, 16'h0000);
        issue(DICS_FN_SENSE, DICS_AM_SEQ, 16'h0041, 16'h0, 16'h1);
        do begin @(negedge clk); k++; end while (accv !== 1'b1 && k < 20);
        `CHK("accv", 1'b1, accv)
        `CHK("acc", 16'h8001, accd)
        settle();
        $display("done t_direct");
    endtask
    task automatic t_counter();
        @(posedge clk) wide[1] <= 1'b1;
        pulses(0, 3);
        pulses(1, 5);
        pulses(2, 2);
        issue(DICS_FN_READ, DICS_AM_SEQ, 16'h007F, 16'h0210, 16'h1);
        take_word("ctr8", 16'h0210, 16'h0503);
        issue(DICS_FN_READ, DICS_AM_SEQ, 16'h007F, 16'h0211, 16'h1);
        take_word("ctrclr", 16'h0211, 16'h0000);
        issue(DICS_FN_READ, DICS_AM_SEQ, 16'h007E, 16'h0212, 16'h1);
        take_word("ctr16", 16'h0212, 16'h0002);
        $display("done t_counter");
    endtask
    task automatic t_pi();
        @(posedge clk) pi[16*23+4*2+1] <= 1'b1;
        @(posedge clk) pi[16*23+4*2+1] <= 1'b0;
        repeat (2) @(negedge clk);
        `CHK("level", {2'b01, 94'h0}, lvl)
        issue(DICS_FN_READ, DICS_AM_SEQ, {9'h0, MOD_PI_LAST}, 16'h0220, 16'h1);
        take_word("pi", 16'h0220, 16'h0200);
        settle();
        `CHK("lvlclr", 96'h0, lvl)
        $display("done t_pi");
    endtask
    task automatic t_chan();
        dics_amode_e m;
        int g;
        for (int a = 0; a < 3; a++) begin
            m = dics_amode_e'(a);
            @(posedge clk) rg <= 7'h46;
            issue(DICS_FN_INIT, m, 16'h0044, 16'h0300, 16'h3);
            @(negedge clk);
            `CHK("hold", 1'b1, hold)
            for (int i = 0; i < 3; i++) begin
                g = (m == DICS_AM_SEQ) ? 4 + i : (m == DICS_AM_RANDOM) ? 6 + i : 4;
                take_word("chan", 16'h0300 + 16'(i), grp(g));
                rg <= rg + 7'h01;
            end
            settle();
        end
        $display("done t_chan");
    endtask
    task automatic t_sync();
        @(posedge clk) tsync <= 1'b1;
        @(posedge clk) tsync <= 1'b0;
        settle();
        `CHK("stray", 1'b0, sr)
        for (int r = 0; r < 2; r++) begin
            dly <= r ? 4'h9 : 4'h1;
            issue(DICS_FN_INIT, DICS_AM_SINGLE, 16'h00C0, 16'h0400, 16'h3);
            @(negedge clk);
            `CHK("armed", 1'b1, sr)
            `CHK("free", 1'b0, hold)
            `CHK("lock", 1'b1, il)
            for (int i = 0; i < 3; i++)
                take_word("sync", 16'h0400 + 16'(i), 16'hA5A1 + 16'(3 * r + i));
            settle();
        end
        $display("done t_sync");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {rstn, cv, ack, tsync, cpul, wide, pi} = '0;
        {n_fail, num_checks} = '0;
        cmd = '0;
        rg = 7'h0;
        dly = 4'h1;
        for (int g = 1; g < NUM_DI; g++) sense[g*16+:16] = grp(g);
        sense[15:0] = 16'h0000;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        `CHK("rstrdy", 1'b1, rdy)
        t_direct();
        t_counter();
        t_pi();
        t_chan();
        t_sync();
        conclude();
    end
    initial begin
        #200us;
        n_fail++;
        conclude();
    end
endmodule // tb
